// ---- hw/main_cfg_pkg.sv ----
// Shared constants, field layouts, reset values and types for the main configuration bank.
package main_cfg_pkg;

  // ==========================================================================
  // Address space layout
  // ==========================================================================
  localparam logic [7:0] MAIN_GROUP_FIRST = 8'h00;
  localparam logic [7:0] MAIN_GROUP_LAST = 8'h0c;
  localparam logic [7:0] IRQ_GROUP_FIRST = 8'h0d;
  localparam logic [7:0] IRQ_GROUP_LAST = 8'h0f;
  localparam logic [7:0] RX_GROUP_FIRST = 8'h10;
  localparam logic [7:0] RX_GROUP_LAST = 8'h15;
  localparam logic [7:0] MAP_LAST = 8'h1f;

  // ==========================================================================
  // Implemented byte offsets
  // ==========================================================================
  localparam int NUM_BYTES = 6;
  localparam logic [7:0] OFS_STATE_BAND_TRIM_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODULATION_DATAPATH_CTRL = 8'h01;
  localparam logic [7:0] OFS_DEVIATION_CODE = 8'h02;
  localparam logic [7:0] OFS_BIT_RATE_CODE = 8'h03;
  localparam logic [7:0] OFS_ONOFF_FLOOR_LEVEL = 8'h04;
  localparam logic [7:0] OFS_BUFFER_SIZE_LEVEL = 8'h05;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RST_STATE_BAND_TRIM_CTRL = 8'h28;
  localparam logic [7:0] RST_MODULATION_DATAPATH_CTRL = 8'h88;
  localparam logic [7:0] RST_DEVIATION_CODE = 8'h03;
  localparam logic [7:0] RST_BIT_RATE_CODE = 8'h07;
  localparam logic [7:0] RST_ONOFF_FLOOR_LEVEL = 8'h0c;
  localparam logic [7:0] RST_BUFFER_SIZE_LEVEL = 8'h0f;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int STATE_HI = 7;
  localparam int STATE_LO = 5;
  localparam int BAND_HI = 4;
  localparam int BAND_LO = 3;
  localparam int TUNE_HI = 2;
  localparam int TUNE_LO = 1;
  localparam int DIVSEL_BIT = 0;
  localparam int MODUL_HI = 7;
  localparam int MODUL_LO = 6;
  localparam int DMODE_LO_BIT = 5;
  localparam int SLICER_HI = 4;
  localparam int SLICER_LO = 3;
  localparam int DMODE_HI_BIT = 2;
  localparam int IFGAIN_HI = 1;
  localparam int IFGAIN_LO = 0;
  localparam int RATE_HI = 6;
  localparam int RATE_LO = 0;
  localparam int BUFSIZE_HI = 7;
  localparam int BUFSIZE_LO = 6;
  localparam int BUFTHR_HI = 5;
  localparam int BUFTHR_LO = 0;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_SLEEP = 3'h0,
    ST_STANDBY = 3'h1,
    ST_SYNTH_ONLY = 3'h2,
    ST_RECEIVE = 3'h3,
    ST_TRANSMIT = 3'h4
  } op_state_t;

  typedef enum logic [1:0] {
    BAND_LOWER = 2'h0,
    BAND_UPPER = 2'h1,
    BAND_ALTERNATE = 2'h2
  } band_t;

  typedef enum logic [1:0] {
    DM_CONTINUOUS = 2'h0,
    DM_BUFFERED = 2'h1,
    DM_PACKET = 2'h2
  } data_mode_t;

  typedef enum logic [1:0] {
    SL_FIXED = 2'h0,
    SL_PEAK = 2'h1,
    SL_AVERAGE = 2'h2,
    SL_RESERVED = 2'h3
  } slicer_t;

  typedef enum logic [1:0] {
    GRP_MAIN = 2'h0,
    GRP_IRQ = 2'h1,
    GRP_RX = 2'h2,
    GRP_NONE = 2'h3
  } group_t;

  // Register request as seen by the bank.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Decoded view of the first two control bytes.
  typedef struct packed {
    logic [2:0] state;
    logic state_valid;
    logic [1:0] band;
    logic band_valid;
    logic [1:0] tune;
    logic div_sel;
    logic [1:0] data_mode;
    logic [1:0] slicer;
    logic slicer_reserved;
  } ctrl_view_t;

endpackage

// ---- hw/cfg_byte.sv ----
// One byte-wide read/write configuration register with a fixed reset value.
`timescale 1ns/1ps
module cfg_byte #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  // Default then hold.
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= RESET_VAL;
    end else if (we) begin
      q <= wdata;
    end
  end

endmodule

// ---- hw/ctrl_decode.sv ----
// Field decoder for the state, band, tuning, divider set, data mode and slicer bits.
`timescale 1ns/1ps
module ctrl_decode (
  input wire logic [7:0] byte0,
  input wire logic [7:0] byte1,
  output main_cfg_pkg::ctrl_view_t view
);

  // ==========================================================================
  // Byte 0 and byte 1 fields
  // ==========================================================================
  wire logic [2:0] state_code = byte0[main_cfg_pkg::STATE_HI:main_cfg_pkg::STATE_LO];
  wire logic [1:0] band_code = byte0[main_cfg_pkg::BAND_HI:main_cfg_pkg::BAND_LO];
  wire logic dm_hi = byte1[main_cfg_pkg::DMODE_HI_BIT];
  wire logic dm_lo = byte1[main_cfg_pkg::DMODE_LO_BIT];
  wire logic [1:0] slicer_code = byte1[main_cfg_pkg::SLICER_HI:main_cfg_pkg::SLICER_LO];
  wire logic state_ok = (state_code <= main_cfg_pkg::ST_TRANSMIT);
  wire logic band_ok = (band_code != 2'h3);
  wire logic [1:0] dm_code = dm_hi ? main_cfg_pkg::DM_PACKET :
                             (dm_lo ? main_cfg_pkg::DM_BUFFERED : main_cfg_pkg::DM_CONTINUOUS);

  // ==========================================================================
  // Packed view
  // ==========================================================================
  assign view.state = state_code;
  assign view.state_valid = state_ok;
  assign view.band = band_code;
  assign view.band_valid = band_ok;
  assign view.tune = byte0[main_cfg_pkg::TUNE_HI:main_cfg_pkg::TUNE_LO];
  assign view.div_sel = byte0[main_cfg_pkg::DIVSEL_BIT];
  assign view.data_mode = dm_code;
  assign view.slicer = slicer_code;
  assign view.slicer_reserved = (slicer_code == main_cfg_pkg::SL_RESERVED);

endmodule

// ---- hw/transceiver_main_config_regs.sv ----
// Top of the byte-wide main configuration register bank and its decoded control outputs.
`timescale 1ns/1ps
module transceiver_main_config_regs (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  output logic [1:0] REG_GROUP,
  output logic REG_UNMAPPED,
  output logic [2:0] OP_STATE,
  output logic OP_STATE_VALID,
  output logic [1:0] FREQ_BAND,
  output logic FREQ_BAND_VALID,
  output logic [1:0] OSCILLATOR_TUNE_OFFSET,
  output logic DIVIDER_SET_SEL,
  output logic [1:0] MODULATION,
  output logic [1:0] DATA_MODE,
  output logic [1:0] ONOFF_SLICER_METHOD,
  output logic SLICER_RESERVED,
  output logic [1:0] IF_GAIN,
  output logic [7:0] DEVIATION,
  output logic [6:0] RATE_CODE,
  output logic [7:0] FLOOR_LEVEL,
  output logic [1:0] BUFFER_SIZE,
  output logic [5:0] BUFFER_LEVEL
);

  // ==========================================================================
  // Request carrier
  // ==========================================================================
  main_cfg_pkg::reg_req_t req;
  assign req.addr = REG_ADDR;
  assign req.wdata = REG_WDATA;
  assign req.wr = REG_WR;
  assign req.rd = REG_RD;

  // ==========================================================================
  // Address decode
  // ==========================================================================
  // Group ranges.
  wire logic in_main = (req.addr <= main_cfg_pkg::MAIN_GROUP_LAST);
  wire logic in_irq = (req.addr >= main_cfg_pkg::IRQ_GROUP_FIRST) &&
                      (req.addr <= main_cfg_pkg::IRQ_GROUP_LAST);
  wire logic in_rx = (req.addr >= main_cfg_pkg::RX_GROUP_FIRST) &&
                     (req.addr <= main_cfg_pkg::RX_GROUP_LAST);
  wire logic in_map = (req.addr <= main_cfg_pkg::MAP_LAST);
  wire logic [1:0] group_code = in_main ? main_cfg_pkg::GRP_MAIN :
                                in_irq ? main_cfg_pkg::GRP_IRQ :
                                in_rx ? main_cfg_pkg::GRP_RX : main_cfg_pkg::GRP_NONE;
  wire logic access = req.wr | req.rd;

  // ==========================================================================
  // Register bytes
  // ==========================================================================
  localparam logic [7:0] OFS_TABLE [main_cfg_pkg::NUM_BYTES] = '{
    main_cfg_pkg::OFS_STATE_BAND_TRIM_CTRL,
    main_cfg_pkg::OFS_MODULATION_DATAPATH_CTRL,
    main_cfg_pkg::OFS_DEVIATION_CODE,
    main_cfg_pkg::OFS_BIT_RATE_CODE,
    main_cfg_pkg::OFS_ONOFF_FLOOR_LEVEL,
    main_cfg_pkg::OFS_BUFFER_SIZE_LEVEL
  };
  localparam logic [7:0] RST_TABLE [main_cfg_pkg::NUM_BYTES] = '{
    main_cfg_pkg::RST_STATE_BAND_TRIM_CTRL,
    main_cfg_pkg::RST_MODULATION_DATAPATH_CTRL,
    main_cfg_pkg::RST_DEVIATION_CODE,
    main_cfg_pkg::RST_BIT_RATE_CODE,
    main_cfg_pkg::RST_ONOFF_FLOOR_LEVEL,
    main_cfg_pkg::RST_BUFFER_SIZE_LEVEL
  };

  logic [7:0] byte_q [main_cfg_pkg::NUM_BYTES];
  logic [main_cfg_pkg::NUM_BYTES-1:0] hit;
  logic [7:0] rd_chain [main_cfg_pkg::NUM_BYTES+1];

  genvar gi;
  generate
    for (gi = 0; gi < main_cfg_pkg::NUM_BYTES; gi = gi + 1) begin : g_byte
      assign hit[gi] = (req.addr == OFS_TABLE[gi]);
      assign rd_chain[gi+1] = hit[gi] ? byte_q[gi] : rd_chain[gi];
      cfg_byte #(
        .RESET_VAL(RST_TABLE[gi])
      ) u_byte (
        .clk(CLK),
        .reset(RESET),
        .we(req.wr & hit[gi]),
        .wdata(req.wdata),
        .q(byte_q[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Read selection
  // ==========================================================================
  // Unimplemented bytes inside the map read as zero, so software can probe the
  // group layout without side effects; there is no bus error path on this port.
  // Offsets are distinct, so at most one link of the chain passes its own byte.
  assign rd_chain[0] = main_cfg_pkg::READ_ZERO;
  wire logic [7:0] read_sel = rd_chain[main_cfg_pkg::NUM_BYTES];

  // ==========================================================================
  // Field decode
  // ==========================================================================
  main_cfg_pkg::ctrl_view_t view;

  ctrl_decode u_decode (
    .byte0(byte_q[0]),
    .byte1(byte_q[1]),
    .view(view)
  );

  // ==========================================================================
  // Access response
  // ==========================================================================
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [1:0] group_q;
  logic unmapped_q;
  // Read data is held at zero outside the answer cycle, so a late sample sees no stale byte.
  wire logic [7:0] rdata_d = req.rd ? read_sel : main_cfg_pkg::READ_ZERO;
  wire logic [1:0] group_d = access ? group_code : group_q;
  wire logic unmapped_d = access & ~in_map;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rdata_q <= main_cfg_pkg::READ_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      group_q <= main_cfg_pkg::GRP_MAIN;
    end else begin
      group_q <= group_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      unmapped_q <= 1'b0;
    end else begin
      unmapped_q <= unmapped_d;
    end
  end

  // ==========================================================================
  // Registered control outputs
  // ==========================================================================
  // The decoded view is re-registered so every output is a flop; the cost is
  // one extra cycle between a write and the decoded field changing.
  main_cfg_pkg::ctrl_view_t view_q;
  logic [1:0] modul_q;
  logic [1:0] ifgain_q;
  logic [7:0] dev_q;
  logic [6:0] rate_q;
  logic [7:0] floor_q;
  logic [1:0] bsize_q;
  logic [5:0] blevel_q;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      view_q <= '0;
    end else begin
      view_q <= view;
    end
  end

  wire logic [1:0] modul_d = byte_q[1][main_cfg_pkg::MODUL_HI:main_cfg_pkg::MODUL_LO];
  wire logic [1:0] ifgain_d = byte_q[1][main_cfg_pkg::IFGAIN_HI:main_cfg_pkg::IFGAIN_LO];
  wire logic [7:0] dev_d = byte_q[2];
  wire logic [6:0] rate_d = byte_q[3][main_cfg_pkg::RATE_HI:main_cfg_pkg::RATE_LO];
  wire logic [7:0] floor_d = byte_q[4];
  wire logic [1:0] bsize_d = byte_q[5][main_cfg_pkg::BUFSIZE_HI:main_cfg_pkg::BUFSIZE_LO];
  wire logic [5:0] blevel_d = byte_q[5][main_cfg_pkg::BUFTHR_HI:main_cfg_pkg::BUFTHR_LO];

  always_ff @(posedge CLK) begin
    if (RESET) begin
      modul_q <= 2'h0;
    end else begin
      modul_q <= modul_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ifgain_q <= 2'h0;
    end else begin
      ifgain_q <= ifgain_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      dev_q <= 8'h00;
    end else begin
      dev_q <= dev_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rate_q <= 7'h00;
    end else begin
      rate_q <= rate_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      floor_q <= 8'h00;
    end else begin
      floor_q <= floor_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      bsize_q <= 2'h0;
    end else begin
      bsize_q <= bsize_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      blevel_q <= 6'h00;
    end else begin
      blevel_q <= blevel_d;
    end
  end

  // ==========================================================================
  // Port drive
  // ==========================================================================
  assign REG_RDATA = rdata_q;
  assign REG_RVALID = rvalid_q;
  assign REG_GROUP = group_q;
  assign REG_UNMAPPED = unmapped_q;
  assign OP_STATE = view_q.state;
  assign OP_STATE_VALID = view_q.state_valid;
  assign FREQ_BAND = view_q.band;
  assign FREQ_BAND_VALID = view_q.band_valid;
  assign OSCILLATOR_TUNE_OFFSET = view_q.tune;
  assign DIVIDER_SET_SEL = view_q.div_sel;
  assign MODULATION = modul_q;
  assign DATA_MODE = view_q.data_mode;
  assign ONOFF_SLICER_METHOD = view_q.slicer;
  // A reserved slicer code is stored and flagged but not acted on.
  assign SLICER_RESERVED = view_q.slicer_reserved;
  assign IF_GAIN = ifgain_q;
  assign DEVIATION = dev_q;
  assign RATE_CODE = rate_q;
  assign FLOOR_LEVEL = floor_q;
  assign BUFFER_SIZE = bsize_q;
  assign BUFFER_LEVEL = blevel_q;

endmodule

// ---- verif/main_cfg_asserts.sv ----
// Concurrent checks on the register port and decoded outputs of the configuration bank.
`timescale 1ns/1ps
module main_cfg_checker (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic [1:0] REG_GROUP,
  input wire logic REG_UNMAPPED,
  input wire logic [2:0] OP_STATE,
  input wire logic [1:0] FREQ_BAND,
  input wire logic [1:0] OSCILLATOR_TUNE_OFFSET,
  input wire logic DIVIDER_SET_SEL,
  input wire logic [1:0] DATA_MODE,
  input wire logic [1:0] ONOFF_SLICER_METHOD,
  input wire logic SLICER_RESERVED,
  input wire logic [7:0] DEVIATION
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Decoded outputs lag a write by two edges, so the expected fields are taken two cycles back.
  wire logic acc = REG_RD || REG_WR;
  wire logic w0 = REG_WR && REG_ADDR == 8'h00;
  wire logic w1 = REG_WR && REG_ADDR == 8'h01;
  wire logic w2 = REG_WR && REG_ADDR == 8'h02;
  wire logic [1:0] wd_mode = REG_WDATA[2] ? 2'h2 : {1'b0, REG_WDATA[5]};
  wire logic [1:0] wd_slicer = REG_WDATA[4:3];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_read_answer: assert property (REG_RD |=> REG_RVALID)
    else $error("read not answered");
  a_read_quiet: assert property (!REG_RD |=> !REG_RVALID)
    else $error("spurious read answer");
  a_group_main: assert property (acc && REG_ADDR <= 8'h0c |=> REG_GROUP == 2'h0)
    else $error("main group not decoded");
  a_group_irq: assert property (acc && REG_ADDR >= 8'h0d && REG_ADDR <= 8'h0f |=>
    REG_GROUP == 2'h1) else $error("interrupt group not decoded");
  a_group_rx: assert property (acc && REG_ADDR >= 8'h10 && REG_ADDR <= 8'h15 |=>
    REG_GROUP == 2'h2) else $error("receiver group not decoded");
  a_unmapped_flag: assert property (acc |=> REG_UNMAPPED == ($past(REG_ADDR) > 8'h1f))
    else $error("unmapped flag wrong");
  a_unmapped_zero: assert property (REG_RD && REG_ADDR > 8'h05 |=> REG_RDATA == 8'h00)
    else $error("unimplemented byte not zero");
  a_byte0_fields: assert property (w0 |=> ##1
    {OP_STATE, FREQ_BAND, OSCILLATOR_TUNE_OFFSET, DIVIDER_SET_SEL} == $past(REG_WDATA, 2))
    else $error("byte 0 fields wrong");
  a_mode_decode: assert property (w1 |=> ##1 DATA_MODE == $past(wd_mode, 2))
    else $error("data mode wrong");
  a_slicer_follow: assert property (w1 |=> ##1 ONOFF_SLICER_METHOD == $past(wd_slicer, 2))
    else $error("slicer method wrong");
  a_slicer_flag: assert property (SLICER_RESERVED == (ONOFF_SLICER_METHOD == 2'h3))
    else $error("slicer flag wrong");
  a_dev_follow: assert property (w2 |=> ##1 DEVIATION == $past(REG_WDATA, 2))
    else $error("deviation wrong");
endmodule

bind transceiver_main_config_regs main_cfg_checker u_chk (.CLK, .RESET, .REG_ADDR, .REG_WDATA,
  .REG_WR, .REG_RD, .REG_RDATA, .REG_RVALID, .REG_GROUP, .REG_UNMAPPED, .OP_STATE, .FREQ_BAND,
  .OSCILLATOR_TUNE_OFFSET, .DIVIDER_SET_SEL, .DATA_MODE, .ONOFF_SLICER_METHOD, .SLICER_RESERVED,
  .DEVIATION);

// ---- verif/host_port_model.sv ----
// Host model that drives the byte register port of the configuration bank.
`timescale 1ns/1ps
module host_port_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  // ==========================================================================
  // Transfers
  // ==========================================================================
  // Released lines show the inverse of the last value, so stale data never looks valid.
  initial begin
    addr = 8'hff;
    wdata = 8'hff;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Reserved defaults kept.
  // Callers pass reserved bits at their defaults; the model adds no bits of its own.
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    addr = ~a;
    d = rdata;
    v = rvalid;
  endtask
endmodule

// ---- verif/test_transceiver_main_config_regs.sv ----
// Self-checking testbench for the main configuration register bank.
`timescale 1ns/1ps
module test_transceiver_main_config_regs;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr, wdata, rdata, dev, floor;
  logic wr, rd, rvalid, unmapped, st_ok, band_ok, div_sel, slc_rsv;
  logic [2:0] op_state;
  logic [1:0] group, band, tune, modul, dmode, slicer, if_gain, bsize;
  logic [6:0] rate;
  logic [5:0] blevel;
  int err_total = 0;
  int n_compared = 0;

  always #50 clk = ~clk;

  host_port_model u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rvalid(rvalid));
  transceiver_main_config_regs DUT (.CLK(clk), .RESET(reset), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .REG_GROUP(group), .REG_UNMAPPED(unmapped), .OP_STATE(op_state), .OP_STATE_VALID(st_ok),
    .FREQ_BAND(band), .FREQ_BAND_VALID(band_ok), .OSCILLATOR_TUNE_OFFSET(tune),
    .DIVIDER_SET_SEL(div_sel), .MODULATION(modul), .DATA_MODE(dmode),
    .ONOFF_SLICER_METHOD(slicer), .SLICER_RESERVED(slc_rsv), .IF_GAIN(if_gain),
    .DEVIATION(dev), .RATE_CODE(rate), .FLOOR_LEVEL(floor), .BUFFER_SIZE(bsize),
    .BUFFER_LEVEL(blevel));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    u_host.rd_byte(a, d, v);
    check({7'h00, v}, 8'h01);
    check(d, exp);
  endtask

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_defaults();
    logic [7:0] dflt [6] = '{8'h28, 8'h88, 8'h03, 8'h07, 8'h0c, 8'h0f};
    for (int i = 0; i < 6; i++) begin
      rc(8'(i), dflt[i]);
    end
    check({5'h0, op_state}, 8'h01);
    check({6'h0, band}, 8'h01);
    check({6'h0, tune}, 8'h00);
    check({7'h0, div_sel}, 8'h00);
    check({6'h0, dmode}, 8'h00);
    check({6'h0, slicer}, 8'h01);
    check(dev, 8'h03);
    check({modul, 4'h0, if_gain}, 8'h80);
    check({6'h0, group}, 8'h00);
    $display("defaults done");
  endtask

  task automatic t_byte0();
    logic [7:0] b;
    for (int i = 0; i < 5; i++) begin
      b = {3'(i), 2'(i % 3), 2'(i % 4), 1'(i % 2)};
      u_host.wr_byte(8'h00, b);
      rc(8'h00, b);
      check({op_state, band, tune, div_sel}, b);
      check({6'h0, st_ok, band_ok}, 8'h03);
    end
    $display("byte 0 fields done");
  endtask

  task automatic t_byte1();
    logic [7:0] b;
    logic [1:0] m;
    for (int i = 0; i < 6; i++) begin
      b = {~i[0], i[0], i[0], 2'(i % 3), i[1], 2'(i % 4)};
      m = i[1] ? 2'h2 : {1'b0, i[0]};
      u_host.wr_byte(8'h01, b);
      rc(8'h01, b);
      check({6'h0, dmode}, {6'h0, m});
      check({6'h0, slicer}, {6'h0, 2'(i % 3)});
      check({7'h0, slc_rsv}, 8'h00);
      check({modul, 4'h0, if_gain}, {~i[0], i[0], 4'h0, 2'(i % 4)});
    end
    $display("byte 1 fields done");
  endtask

  task automatic t_bytes();
    u_host.wr_byte(8'h02, 8'h00);
    rc(8'h02, 8'h00);
    u_host.wr_byte(8'h02, 8'hff);
    u_host.wr_byte(8'h03, 8'h7f);
    u_host.wr_byte(8'h04, 8'ha5);
    u_host.wr_byte(8'h05, 8'hc5);
    rc(8'h02, 8'hff);
    check(dev, 8'hff);
    rc(8'h03, 8'h7f);
    rc(8'h04, 8'ha5);
    rc(8'h05, 8'hc5);
    check({1'b0, rate}, 8'h7f);
    check(floor, 8'ha5);
    check({bsize, blevel}, 8'hc5);
    @(posedge clk);
    #1;
    reset = 1'b1;
    @(posedge clk);
    #1;
    reset = 1'b0;
    rc(8'h02, 8'h03);
    check(dev, 8'h03);
    $display("data bytes done");
  endtask

  task automatic t_map();
    logic [7:0] adr [9] = '{8'h0c, 8'h0d, 8'h0f, 8'h10, 8'h15, 8'h16, 8'h1f, 8'h20, 8'hff};
    logic [1:0] g;
    for (int i = 0; i < 9; i++) begin
      g = adr[i] <= 8'h0c ? 2'h0 : adr[i] <= 8'h0f ? 2'h1 : adr[i] <= 8'h15 ? 2'h2 : 2'h3;
      rc(adr[i], 8'h00);
      check({6'h0, group}, {6'h0, g});
      check({7'h0, unmapped}, {7'h0, adr[i] > 8'h1f});
    end
    $display("address map done");
  endtask

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    t_defaults();
    t_byte0();
    t_byte1();
    t_bytes();
    t_map();
    conclude();
  end

  // A hung run is cut short and counted as a mismatch.
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule
